/* File: include/hhb_pkg.sv */
// Shared constants for the half-bridge control block: frame layout, reset values, timing.
// Assumes a 40 MHz system clock and a 16-bit serial command frame.
package hhb_pkg;

    localparam int          FRAME_BITS          = 16;
    localparam int          NUM_SW              = 12;
    localparam int          NUM_SENSORS         = 6;
    localparam int          NUM_PIN_SYNC        = 43;
    localparam int          NUM_LINK_SYNC       = 22;

    localparam int          IN_OVERVOLTAGE_SHUTDOWN_ENABLE_BIT         = 15;
    localparam int          IN_ULD_BIT          = 14;
    localparam int          IN_OCD_BIT          = 13;
    localparam int          SW_HI_BIT           = 12;
    localparam int          SW_LO_BIT           = 1;
    localparam int          IN_CLR_BIT          = 0;

    localparam int          ST_SUPPLY_FAIL_BIT  = 15;
    localparam int          ST_UNDERLOAD_BIT    = 14;
    localparam int          ST_OVERLOAD_BIT     = 13;
    localparam int          ST_THERMAL_BIT      = 0;

    localparam logic [11:0] SW_RST              = 12'h000;
    localparam logic [15:0] STATUS_RST          = 16'h0000;
    localparam logic [15:0] WORD_RST            = 16'h0000;
    localparam logic        ENABLE_RST          = 1'h0;

    localparam logic [3:0]  CNT_FIRST           = 4'h1;
    localparam logic [3:0]  CNT_LAST            = 4'hf;
    localparam logic [3:0]  CNT_WORD_END        = 4'h0;

    localparam int          CLK_PERIOD_NS       = 25;
    localparam int          UL_DELAY_NS         = 200000;
    localparam int          UL_DELAY_CYC        = (UL_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

/* File: include/hhb_ul_if.sv */
// Carrier between the control core and one under-load timer.
// Assumes both ends sit on the system clock.
`timescale 1ns/1ps
`default_nettype none
interface hhb_ul_if;
    logic armed;
    logic expired;
    modport timer (input armed, output expired);
    modport owner (output armed, input expired);
endinterface
`default_nettype wire

/* File: design/hhb_sync.sv */
// Two-stage synchroniser for a bundle of quasi-static levels.
// Assumes each bit is a level that stays put for several destination clocks.
`timescale 1ns/1ps
`default_nettype none
module hhb_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_r;
    logic [W-1:0] q_r;

    always_ff @(posedge clk_i)
    begin
        meta_r <= d_i;
        q_r    <= meta_r;
    end

    assign q_o = q_r;
endmodule // hhb_sync
`default_nettype wire

/* File: design/hhb_ul_timer.sv */
// Under-load delay timer for one output switch.
// Assumes armed is a registered level from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module hhb_ul_timer #(
    parameter int unsigned DELAY_CYC = 8000
) (
    input  wire logic  clk_i,
    input  wire logic  rst_i,
    hhb_ul_if.timer    ul
);
    localparam int unsigned     CW    = $clog2(DELAY_CYC + 1);
    localparam logic [CW-1:0]   LIMIT = CW'(DELAY_CYC);

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    wire           at_limit = (cnt_r == LIMIT);

    // The count restarts whenever the low-current condition breaks.
    assign cnt_nxt    = !ul.armed ? '0 : (at_limit ? cnt_r : cnt_r + CW'(1));
    assign ul.expired = at_limit;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cnt_r <= '0;
        else
            cnt_r <= cnt_nxt;
    end
endmodule // hhb_ul_timer
`default_nettype wire

/* File: design/hhb_top.sv */
// Control and protection core of a twelve-channel half-bridge driver with a serial command port.
// Assumes fault and supply monitors arrive as asynchronous levels, and SCLK_I idles
// whenever CHIP_SELECT_N_I is high.
//
// Function
// - While asleep, no switch selection or fault flag is kept.
// - Every switch starts off and stays off until commanded on.
// - Any supply below its lockout level forces all switches off.
// - A live switch only drops on undervoltage, a command, a fault, sleep or reset.
// - Logic resets at power-up; frames are ignored while logic supply is low.
// - Programmed state survives the whole driver-supply range.
// - Overcurrent with shutdown enabled latches that output off until clear.
// - No output turns on while the die is over temperature.
// - Low current beyond the delay on a live output sets the under-load flag.
// - Only with under-load shutdown enabled does that output latch off.
// - Over-voltage on either driver supply sets the supply-fail flag.
// - With over-voltage shutdown enabled, all outputs stay off during over-voltage.
// - Over-voltage blanking keeps the selection and restores it afterwards.
// - Thermal warning sets status bit 0 and leaves outputs on.
// - Any one of six sensors over temperature turns every channel off.
// - Over-temperature blanking keeps the selection; outputs resume after cooling.
// - Thermal warning stays latched until the host sends status clear.
// - Chip select falling puts the thermal warning on serial out at once.
// - Serial out shows 0 without warning and 1 with warning.
// - Frames are 16 bits, LSB first, sampled on falling serial clock.
// - Data applies on chip select rising, only for whole multiples of 16.
// - Input word: enables at 15..13, switches at 12..1, clear at 0.
// - Status word shifts out: warning, switches, overload, under-load, fail.
`timescale 1ns/1ps
`default_nettype none
module hhb_top #(
    parameter int unsigned UL_DELAY_CYC = hhb_pkg::UL_DELAY_CYC
) (
    input  wire logic        SYS_CLK_I,
    input  wire logic        RESET_I,
    input  wire logic        ENABLE_I,
    input  wire logic        CHIP_SELECT_N_I,
    input  wire logic        SCLK_I,
    input  wire logic        SI_I,
    output logic             SO_O,
    output logic             SO_OE_O,
    input  wire logic        VCC_UV_I,
    input  wire logic        DRIVER_SUPPLY_A_UV_I,
    input  wire logic        DRIVER_SUPPLY_B_UV_I,
    input  wire logic        DRIVER_SUPPLY_A_OV_I,
    input  wire logic        DRIVER_SUPPLY_B_OV_I,
    input  wire logic [11:0] OVERCURRENT_I,
    input  wire logic [11:0] UNDERLOAD_I,
    input  wire logic [5:0]  THERMAL_WARN_I,
    input  wire logic [5:0]  OVER_TEMP_I,
    output logic      [11:0] HALF_BRIDGE_OUTPUT_O
);

    // ---------------- System-side input synchronisation ----------------
    logic [hhb_pkg::NUM_PIN_SYNC-1:0]  pin_raw;
    logic [hhb_pkg::NUM_PIN_SYNC-1:0]  pin_s;

    assign pin_raw = {CHIP_SELECT_N_I, ENABLE_I, VCC_UV_I,
                      DRIVER_SUPPLY_A_UV_I, DRIVER_SUPPLY_B_UV_I,
                      DRIVER_SUPPLY_A_OV_I, DRIVER_SUPPLY_B_OV_I,
                      OVERCURRENT_I, UNDERLOAD_I, THERMAL_WARN_I, OVER_TEMP_I};

    hhb_sync #(
        .W    (hhb_pkg::NUM_PIN_SYNC)
    ) u_pin_sync (
        .clk_i (SYS_CLK_I),
        .d_i   (pin_raw),
        .q_o   (pin_s)
    );

    wire        cs_n_s   = pin_s[42];
    wire        enable_s = pin_s[41];
    wire        vcc_uv_s = pin_s[40];
    wire        a_uv_s   = pin_s[39];
    wire        b_uv_s   = pin_s[38];
    wire        a_ov_s   = pin_s[37];
    wire        b_ov_s   = pin_s[36];
    wire [11:0] oc_s     = pin_s[35:24];
    wire [11:0] ul_s     = pin_s[23:12];
    wire [5:0]  tw_s     = pin_s[11:6];
    wire [5:0]  ot_s     = pin_s[5:0];

    // ---------------- Reset and sleep ----------------
    logic core_rst_r;
    logic link_rst_r;

    // Sleep drops everything, so leaving sleep looks exactly like a power-up.
    wire  core_rst_nxt = RESET_I | ~enable_s;

    always_ff @(posedge SYS_CLK_I)
    begin
        core_rst_r <= core_rst_nxt;
        link_rst_r <= core_rst_nxt;
    end

    // ---------------- Link domain: serial receive on falling clock ----------------
    logic [15:0] rx_sh_r;
    logic [3:0]  bit_cnt_r;
    logic        got_word_r;
    logic        frame_tog_r;
    logic        rx_first_r;
    logic        tx_first_r;
    logic [15:0] tx_sh_r;
    logic [15:0] snap_r;

    // Chip select high re-arms the frame start without needing a serial clock edge.
    wire         link_arm = CHIP_SELECT_N_I | link_rst_r;

    always_ff @(negedge SCLK_I or posedge link_arm)
    begin
        if (link_arm)
            rx_first_r <= 1'b1;
        else
            rx_first_r <= 1'b0;
    end

    always_ff @(negedge SCLK_I or posedge link_rst_r)
    begin
        if (link_rst_r)
        begin
            rx_sh_r     <= hhb_pkg::WORD_RST;
            bit_cnt_r   <= hhb_pkg::CNT_WORD_END;
            got_word_r  <= 1'b0;
            frame_tog_r <= 1'b0;
        end
        else
        begin
            rx_sh_r <= {SI_I, rx_sh_r[15:1]};
            if (rx_first_r)
            begin
                bit_cnt_r   <= hhb_pkg::CNT_FIRST;
                got_word_r  <= 1'b0;
                frame_tog_r <= ~frame_tog_r;
            end
            else
            begin
                bit_cnt_r   <= bit_cnt_r + 4'h1;
                got_word_r  <= got_word_r | (bit_cnt_r == hhb_pkg::CNT_LAST);
            end
        end
    end

    // ---------------- Link domain: serial transmit on rising clock ----------------
    always_ff @(posedge SCLK_I or posedge link_arm)
    begin
        if (link_arm)
            tx_first_r <= 1'b1;
        else
            tx_first_r <= 1'b0;
    end

    // After the status word, the input stream follows so that parts can be chained.
    always_ff @(posedge SCLK_I or posedge link_rst_r)
    begin
        if (link_rst_r)
            tx_sh_r <= hhb_pkg::WORD_RST;
        else if (tx_first_r)
            tx_sh_r <= {1'b0, snap_r[15:1]};
        else
            tx_sh_r <= {rx_sh_r[15], tx_sh_r[15:1]};
    end

    // Before the first rising edge the warning bit shows straight from the snapshot.
    assign SO_O    = tx_first_r ? snap_r[hhb_pkg::ST_THERMAL_BIT] : tx_sh_r[0];
    assign SO_OE_O = ~CHIP_SELECT_N_I;

    // ---------------- Frame handover into the system domain ----------------
    logic [hhb_pkg::NUM_LINK_SYNC-1:0] link_raw;
    logic [hhb_pkg::NUM_LINK_SYNC-1:0] link_s;

    assign link_raw = {frame_tog_r, got_word_r, bit_cnt_r, rx_sh_r};

    // The link words are quiet while chip select is high, so they settle before its edge.
    hhb_sync #(
        .W    (hhb_pkg::NUM_LINK_SYNC)
    ) u_link_sync (
        .clk_i (SYS_CLK_I),
        .d_i   (link_raw),
        .q_o   (link_s)
    );

    wire        lk_tog  = link_s[21];
    wire        lk_word = link_s[20];
    wire [3:0]  lk_cnt  = link_s[19:16];
    wire [15:0] lk_data = link_s[15:0];

    logic cs_n_d_r;
    logic tog_seen_r;

    wire  cs_rise   = cs_n_s & ~cs_n_d_r;
    wire  len_ok    = lk_word & (lk_cnt == hhb_pkg::CNT_WORD_END);
    wire  new_frame = lk_tog ^ tog_seen_r;
    wire  frame_ok  = cs_rise & len_ok & new_frame & ~vcc_uv_s;

    always_ff @(posedge SYS_CLK_I)
    begin
        if (core_rst_r)
        begin
            cs_n_d_r   <= 1'b1;
            tog_seen_r <= 1'b0;
        end
        else
        begin
            cs_n_d_r   <= cs_n_s;
            if (cs_rise)
                tog_seen_r <= lk_tog;
        end
    end

    // ---------------- Programmed state ----------------
    logic [11:0] sw_sel_r;
    logic [11:0] sw_sel_nxt;
    logic        overvoltage_shutdown_enable_en_r;
    logic        uld_en_r;
    logic        ocd_en_r;
    wire         status_clear = frame_ok & lk_data[hhb_pkg::IN_CLR_BIT];

    assign sw_sel_nxt = frame_ok ? lk_data[hhb_pkg::SW_HI_BIT:hhb_pkg::SW_LO_BIT] : sw_sel_r;

    // Supply faults never touch this state; only reset, sleep or a frame do.
    always_ff @(posedge SYS_CLK_I)
    begin
        if (core_rst_r)
        begin
            sw_sel_r  <= hhb_pkg::SW_RST;
            overvoltage_shutdown_enable_en_r <= hhb_pkg::ENABLE_RST;
            uld_en_r  <= hhb_pkg::ENABLE_RST;
            ocd_en_r  <= hhb_pkg::ENABLE_RST;
        end
        else if (frame_ok)
        begin
            sw_sel_r  <= sw_sel_nxt;
            overvoltage_shutdown_enable_en_r <= lk_data[hhb_pkg::IN_OVERVOLTAGE_SHUTDOWN_ENABLE_BIT];
            uld_en_r  <= lk_data[hhb_pkg::IN_ULD_BIT];
            ocd_en_r  <= lk_data[hhb_pkg::IN_OCD_BIT];
        end
    end

    // ---------------- Output gating ----------------
    logic [11:0] latch_off_r;
    logic [11:0] drive_r;

    wire  uv_any    = vcc_uv_s | a_uv_s | b_uv_s;
    wire  ov_any    = a_ov_s | b_ov_s;
    wire  ot_any    = |ot_s;
    wire  ov_blank  = overvoltage_shutdown_enable_en_r & ov_any;
    // Blanking is a gate, not a write, so selections come back on their own.
    wire  all_off   = uv_any | ov_blank | ot_any;
    wire  [11:0] drive_nxt = sw_sel_r & ~latch_off_r & {12{~all_off}};

    always_ff @(posedge SYS_CLK_I)
    begin
        if (core_rst_r)
            drive_r <= hhb_pkg::SW_RST;
        else
            drive_r <= drive_nxt;
    end

    assign HALF_BRIDGE_OUTPUT_O = drive_r;

    // ---------------- Under-load timers ----------------
    logic [11:0] ul_exp;

    genvar gi;
    generate
        for (gi = 0; gi < hhb_pkg::NUM_SW; gi++)
        begin : g_ul
            hhb_ul_if ul_link ();

            assign ul_link.armed = drive_r[gi] & ul_s[gi];
            assign ul_exp[gi]    = ul_link.expired;

            hhb_ul_timer #(
                .DELAY_CYC (UL_DELAY_CYC)
            ) u_timer (
                .clk_i (SYS_CLK_I),
                .rst_i (core_rst_r),
                .ul    (ul_link)
            );
        end
    endgenerate

    // ---------------- Fault flags ----------------
    logic supply_fail_flag_r;
    logic underload_flag_r;
    logic overload_flag_r;
    logic thermal_warning_flag_r;

    wire  [11:0] oc_hit    = oc_s & drive_r;
    wire  [11:0] oc_kill   = oc_hit & {12{ocd_en_r}};
    wire  [11:0] ul_kill   = ul_exp & {12{uld_en_r}};
    wire         fail_set  = ov_any | a_uv_s | b_uv_s;

    // A fault seen in the same cycle as the clear survives it.
    always_ff @(posedge SYS_CLK_I)
    begin
        if (core_rst_r)
        begin
            latch_off_r            <= hhb_pkg::SW_RST;
            supply_fail_flag_r     <= 1'b0;
            underload_flag_r       <= 1'b0;
            overload_flag_r        <= 1'b0;
            thermal_warning_flag_r <= 1'b0;
        end
        else
        begin
            latch_off_r            <= (latch_off_r & {12{~status_clear}})
                                      | oc_kill | ul_kill;
            supply_fail_flag_r     <= (supply_fail_flag_r & ~status_clear) | fail_set;
            underload_flag_r       <= (underload_flag_r & ~status_clear) | (|ul_exp);
            overload_flag_r        <= (overload_flag_r & ~status_clear) | (|oc_hit);
            thermal_warning_flag_r <= (thermal_warning_flag_r & ~status_clear)
                                      | (|tw_s);
        end
    end

    // ---------------- Status snapshot for the link ----------------
    logic [15:0] status_word;

    assign status_word = {supply_fail_flag_r, underload_flag_r, overload_flag_r,
                          drive_r, thermal_warning_flag_r};

    // Frozen while selected, so the serial clock domain reads a still word.
    always_ff @(posedge SYS_CLK_I)
    begin
        if (core_rst_r)
            snap_r <= hhb_pkg::STATUS_RST;
        else if (cs_n_s)
            snap_r <= status_word;
    end

endmodule // hhb_top
`default_nettype wire

/* File: testbench/hhb_top_asserts.sv */
// Concurrent checks on the ports of the half-bridge control core.
// Assumes monitor inputs change only at system clock edges.
`timescale 1ns/1ps
`default_nettype none
module hhb_top_asserts (
    input wire logic        SYS_CLK_I,
    input wire logic        RESET_I,
    input wire logic        ENABLE_I,
    input wire logic        CHIP_SELECT_N_I,
    input wire logic        SO_O,
    input wire logic        SO_OE_O,
    input wire logic        VCC_UV_I,
    input wire logic        DRIVER_SUPPLY_A_UV_I,
    input wire logic        DRIVER_SUPPLY_B_UV_I,
    input wire logic        DRIVER_SUPPLY_A_OV_I,
    input wire logic        DRIVER_SUPPLY_B_OV_I,
    input wire logic [11:0] OVERCURRENT_I,
    input wire logic [11:0] UNDERLOAD_I,
    input wire logic [5:0]  THERMAL_WARN_I,
    input wire logic [5:0]  OVER_TEMP_I,
    input wire logic [11:0] HALF_BRIDGE_OUTPUT_O
);
    logic [3:0] quiet_r;
    wire logic  fault_any = VCC_UV_I | DRIVER_SUPPLY_A_UV_I | DRIVER_SUPPLY_B_UV_I
                          | DRIVER_SUPPLY_A_OV_I | DRIVER_SUPPLY_B_OV_I | (|OVER_TEMP_I);
    wire logic  load_any  = (|OVERCURRENT_I) | (|UNDERLOAD_I);

    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (RESET_I);

    // Outputs may come back by themselves only shortly after a blanking fault ends.
    always_ff @(posedge SYS_CLK_I)
    begin
        if (RESET_I || fault_any)
            quiet_r <= 4'h0;
        else if (quiet_r != 4'hf)
            quiet_r <= quiet_r + 4'h1;
    end

    property p_oe; SO_OE_O == !CHIP_SELECT_N_I; endproperty
    property p_rst; $fell(RESET_I) |-> HALF_BRIDGE_OUTPUT_O == 12'h000; endproperty
    property p_sleep; !ENABLE_I [*5] |-> HALF_BRIDGE_OUTPUT_O == 12'h000; endproperty
    property p_uv;
        (VCC_UV_I || DRIVER_SUPPLY_A_UV_I || DRIVER_SUPPLY_B_UV_I) [*5]
            |-> HALF_BRIDGE_OUTPUT_O == 12'h000;
    endproperty
    property p_ot; (|OVER_TEMP_I) [*5] |-> HALF_BRIDGE_OUTPUT_O == 12'h000; endproperty
    property p_tw;
        ((|THERMAL_WARN_I) && CHIP_SELECT_N_I && ENABLE_I) [*6] ##1 !CHIP_SELECT_N_I |-> SO_O;
    endproperty
    property p_stable;
        (!CHIP_SELECT_N_I && ENABLE_I && !fault_any && !load_any) [*6]
            |-> $stable(HALF_BRIDGE_OUTPUT_O);
    endproperty
    property p_rise;
        |(HALF_BRIDGE_OUTPUT_O & ~$past(HALF_BRIDGE_OUTPUT_O))
            |-> $past(CHIP_SELECT_N_I) || quiet_r < 4'h8;
    endproperty

    a_oe: assert property (p_oe) else $error("serial out enable wrong");
    a_rst: assert property (p_rst) else $error("outputs on after reset");
    a_sleep: assert property (p_sleep) else $error("outputs on in sleep");
    a_uv: assert property (p_uv) else $error("outputs on in lockout");
    a_ot: assert property (p_ot) else $error("outputs on over temp");
    a_tw: assert property (p_tw) else $error("warning not on serial out");
    a_stable: assert property (p_stable) else $error("outputs moved in frame");
    a_rise: assert property (p_rise) else $error("output turned on uncommanded");

    c_frame: cover property ($rose(CHIP_SELECT_N_I));
    c_ot: cover property ((|OVER_TEMP_I) [*5]);
    c_tw: cover property (p_tw);
endmodule // hhb_top_asserts

bind hhb_top hhb_top_asserts chk_u (
    .SYS_CLK_I(SYS_CLK_I), .RESET_I(RESET_I), .ENABLE_I(ENABLE_I), .SO_O(SO_O),
    .CHIP_SELECT_N_I(CHIP_SELECT_N_I), .SO_OE_O(SO_OE_O), .VCC_UV_I(VCC_UV_I),
    .DRIVER_SUPPLY_A_UV_I(DRIVER_SUPPLY_A_UV_I), .DRIVER_SUPPLY_B_UV_I(DRIVER_SUPPLY_B_UV_I),
    .DRIVER_SUPPLY_A_OV_I(DRIVER_SUPPLY_A_OV_I), .DRIVER_SUPPLY_B_OV_I(DRIVER_SUPPLY_B_OV_I),
    .OVERCURRENT_I(OVERCURRENT_I), .UNDERLOAD_I(UNDERLOAD_I), .OVER_TEMP_I(OVER_TEMP_I),
    .THERMAL_WARN_I(THERMAL_WARN_I), .HALF_BRIDGE_OUTPUT_O(HALF_BRIDGE_OUTPUT_O)
);
`default_nettype wire

/* File: testbench/hhb_host_model.sv */
// Serial host model driving the command link of the half-bridge core.
// Assumes a 32 ns link clock that runs only inside frames.
`timescale 1ns/1ps
`default_nettype none
module hhb_host_model (
    output logic      chip_select_n_o,
    output logic      sclk_o,
    output logic      si_o,
    input  wire logic so_i
);
    // Idle levels match the pin pulls, so a released line never shows stale data.
    initial
    begin
        chip_select_n_o = 1'b1;
        sclk_o = 1'b0;
        si_o = 1'b0;
    end
    task automatic xfer(input logic [31:0] w, input int nb, output logic [15:0] s);
        s = 16'h0000;
        chip_select_n_o = 1'b0;
        #5;
        s[0] = so_i;
        #107;
        // Data moves on the rising edge, so it never changes in the step that samples it.
        for (int i = 0; i < nb; i++)
        begin
            #16;
            if (i < 16)
                s[i] = so_i;
            sclk_o = 1'b1;
            si_o = w[i];
            #16;
            sclk_o = 1'b0;
        end
        #16;
        chip_select_n_o = 1'b1;
        si_o = 1'b0;
        #400;
    endtask
endmodule // hhb_host_model
`default_nettype wire

/* File: testbench/hhb_top_bench.sv */
// Self-checking bench for the half-bridge control core.
// Assumes the host model owns the link pins; monitors are driven here.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin n_fail++; \
    $display("BAD %s expected %h seen %h", n, e, a); end end
module hhb_top_bench;
    logic        clk, rst, en, csn, sclk, si, so, so_oe;
    logic        vuv, auv, buv, aov, bov;
    logic [11:0] oc, ul, hb, sw;
    logic [5:0]  tw, ot;
    logic [15:0] st, w;
    int          n_fail, n_compared;

    hhb_top #(.UL_DELAY_CYC(8)) dut_u (
        .SYS_CLK_I(clk), .RESET_I(rst), .ENABLE_I(en), .CHIP_SELECT_N_I(csn),
        .SCLK_I(sclk), .SI_I(si), .SO_O(so), .SO_OE_O(so_oe), .VCC_UV_I(vuv),
        .DRIVER_SUPPLY_A_UV_I(auv), .DRIVER_SUPPLY_B_UV_I(buv),
        .DRIVER_SUPPLY_A_OV_I(aov), .DRIVER_SUPPLY_B_OV_I(bov), .OVERCURRENT_I(oc),
        .UNDERLOAD_I(ul), .THERMAL_WARN_I(tw), .OVER_TEMP_I(ot), .HALF_BRIDGE_OUTPUT_O(hb)
    );
    hhb_host_model host_u (.chip_select_n_o(csn), .sclk_o(sclk), .si_o(si), .so_i(so));

    function automatic logic [15:0] mk(input logic [2:0] e, input logic [11:0] s,
                                       input logic c);
        return {e, s, c};
    endfunction
    function automatic logic [11:0] cut(input logic [11:0] s, input logic [11:0] f);
        return s & ~f;
    endfunction
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic frame(input logic [15:0] f);
        host_u.xfer({16'h0000, f}, 16, st);
        wt(8);
    endtask
    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // A hang counts as a mismatch rather than stalling the run.
    initial
    begin
        repeat (100000) @(posedge clk);
        n_fail++;
        print_verdict;
    end

    initial
    begin
        rst = 1'b1;
        en = 1'b1;
        {vuv, auv, buv, aov, bov, oc, ul, tw, ot} = '0;
        n_fail = 0;
        n_compared = 0;
        void'($urandom(89));
        wt(3);
        rst <= 1'b0;
        wt(4);
        `CHK("out", 12'h000, hb)
        sw = 12'h000;
        for (int i = 0; i < 6; i++)
        begin
            w = mk(3'h0, 12'($urandom), 1'b0);
            frame(w);
            `CHK("status", sw, st[12:1])
            sw = w[12:1];
            `CHK("out", sw, hb)
        end
        host_u.xfer({16'h0000, ~w}, 15, st);
        wt(8);
        `CHK("short", sw, hb)
        host_u.xfer({mk(3'h0, 12'h5a5, 1'b0), ~w}, 32, st);
        wt(8);
        `CHK("long", 12'h5a5, hb)
        oc <= 12'h001;
        wt(8);
        `CHK("oc kept", 12'h5a5, hb)
        oc <= 12'h000;
        frame(mk(3'h1, 12'h5a5, 1'b1));
        `CHK("overload", 1'b1, st[13])
        oc <= 12'h004;
        wt(8);
        oc <= 12'h000;
        wt(8);
        `CHK("oc latch", cut(12'h5a5, 12'h004), hb)
        frame(mk(3'h1, 12'h5a5, 1'b1));
        frame(mk(3'h0, 12'h0ff, 1'b0));
        `CHK("reon", 12'h0ff, hb)
        ot <= 6'h20;
        wt(8);
        `CHK("ot", 12'h000, hb)
        frame(mk(3'h0, 12'h0f0, 1'b0));
        `CHK("ot on", 12'h000, hb)
        ot <= 6'h00;
        wt(8);
        `CHK("cool", 12'h0f0, hb)
        aov <= 1'b1;
        wt(8);
        `CHK("ov kept", 12'h0f0, hb)
        aov <= 1'b0;
        frame(mk(3'h4, 12'h0ff, 1'b1));
        `CHK("supply", 1'b1, st[15])
        bov <= 1'b1;
        wt(8);
        `CHK("ov off", 12'h000, hb)
        bov <= 1'b0;
        wt(8);
        `CHK("ov back", 12'h0ff, hb)
        tw <= 6'h08;
        wt(8);
        host_u.xfer(32'h0, 0, st);
        `CHK("tw so", 1'b1, st[0])
        `CHK("tw out", 12'h0ff, hb)
        wt(1);
        tw <= 6'h00;
        frame(mk(3'h4, 12'h0ff, 1'b0));
        `CHK("tw hold", 1'b1, st[0])
        frame(mk(3'h4, 12'h0ff, 1'b1));
        host_u.xfer(32'h0, 0, st);
        `CHK("tw clear", 1'b0, st[0])
        frame(mk(3'h2, 12'h0ff, 1'b0));
        ul <= 12'h010;
        wt(20);
        ul <= 12'h000;
        frame(mk(3'h2, 12'h0ff, 1'b1));
        `CHK("underload", 1'b1, st[14])
        `CHK("ul off", cut(12'h0ff, 12'h010), st[12:1])
        frame(mk(3'h0, 12'h0ff, 1'b0));
        {auv, buv} <= 2'b11;
        wt(8);
        `CHK("uv", 12'h000, hb)
        {auv, buv} <= 2'b00;
        vuv <= 1'b1;
        frame(mk(3'h0, 12'h00f, 1'b0));
        vuv <= 1'b0;
        wt(8);
        `CHK("uv back", 12'h0ff, hb)
        en <= 1'b0;
        wt(8);
        `CHK("sleep", 12'h000, hb)
        en <= 1'b1;
        wt(8);
        frame(mk(3'h0, 12'h000, 1'b0));
        `CHK("lost", 16'h0000, st)
        print_verdict;
    end
endmodule // hhb_top_bench
`default_nettype wire
